// File: src/wme_pkg.sv
// package: register map, field layout and shared types of the write multiple ext command block
package wme_pkg;
	// ****************************************
	// register byte addresses
	// ****************************************
	localparam logic [7:0] ADDR_ERROR_FLAGS = 8'h00;
	localparam logic [7:0] ADDR_TRANSFER_COUNT = 8'h04;
	localparam logic [7:0] ADDR_BLOCK_ADDRESS_LOW = 8'h08;
	localparam logic [7:0] ADDR_BLOCK_ADDRESS_MID = 8'h0c;
	localparam logic [7:0] ADDR_BLOCK_ADDRESS_HIGH = 8'h10;
	localparam logic [7:0] ADDR_DRIVE_SELECT_HEAD = 8'h14;
	localparam logic [7:0] ADDR_COMMAND_STATUS = 8'h18;
	localparam logic [7:0] ADDR_COMMAND = 8'h1c;
	localparam logic [7:0] ADDR_DEVICE_CONTROL = 8'h20;
	localparam logic [7:0] ADDR_BLOCK_SIZE = 8'h24;
	localparam logic [7:0] ADDR_MEDIA_EVENT = 8'h28;
	localparam logic [7:0] ADDR_DATA = 8'h2c;
	localparam logic [7:0] ADDR_PROGRESS = 8'h30;
	// ****************************************
	// field positions and codes
	// ****************************************
	localparam int STAT_BSY = 7;
	localparam int STAT_DRDY = 6;
	localparam int STAT_DF = 5;
	localparam int STAT_DRQ = 3;
	localparam int STAT_ERR = 0;
	localparam int ERR_WP = 6;
	localparam int ERR_MC = 5;
	localparam int ERR_IDNF = 4;
	localparam int ERR_MCR = 3;
	localparam int ERR_ABRT = 2;
	localparam int ERR_NM = 1;
	localparam int CTL_HOB = 7;
	localparam int DEV_BIT = 4;
	localparam int LBA_MODE_BIT = 6;
	localparam logic [7:0] CMD_WRITE_MULTIPLE_EXT = 8'h39;
	localparam logic [7:0] CMD_GET_MEDIA_STATUS = 8'hda;
	localparam logic [7:0] CMD_SET_MULTIPLE = 8'hc6;
	localparam logic [7:0] DEFAULT_BLOCK_SIZE = 8'h10;
	localparam logic [16:0] COUNT_ZERO_MEANS = 17'h10000;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	localparam logic [7:0] RESET_STATUS = 8'h40;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_BLOCK = 4'h2,
		ST_WRITE = 4'h4,
		ST_DONE = 4'h8
	} wme_state_t;
	// two-byte history of one taskfile register
	typedef struct packed
	{
		logic [7:0] prev;
		logic [7:0] cur;
	} wme_hist_t;
	// media conditions from the drive mechanics
	typedef struct packed
	{
		logic write_protect;
		logic changed;
		logic change_request;
		logic no_media;
		logic fault;
		logic write_error;
		logic range_error;
	} wme_media_t;
endpackage : wme_pkg

// File: src/wme_sync.sv
// two-flop synchroniser for media condition pins
`timescale 1ns/100ps
module wme_sync #(parameter int WIDTH = 7)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// async in, synced out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] q_ff;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_ff <= '0;
			q_ff <= '0;
		end
		else
		begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end
	assign q = q_ff;
endmodule : wme_sync

// File: src/wme_blocker.sv
// block splitter: length of the next block from sectors left and block size
`timescale 1ns/100ps
module wme_blocker
(
	// request
	input wire logic [16:0] sectors_left,
	input wire logic [7:0] block_size,
	// answer
	output logic [16:0] block_len
);
	// last block takes what is left once no more than block size sectors remain
	always_comb
	begin
		if (sectors_left < {9'h000, block_size})
			block_len = sectors_left;
		else
			block_len = {9'h000, block_size};
	end
endmodule : wme_blocker

// File: src/wme_top.sv
// top: axi4-lite taskfile and write multiple ext sequencer
`timescale 1ns/100ps
module wme_top
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// media condition pins
	input wire wme_pkg::wme_media_t media_in,
	// media write side
	output logic [15:0] sector_word,
	output logic sector_word_valid,
	output logic [47:0] media_lba,
	output logic media_commit,
	input wire logic media_done,
	// interrupt pending to host link
	output logic intrq
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed
	{
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		wme_pkg::wme_hist_t count;
		wme_pkg::wme_hist_t lba_lo;
		wme_pkg::wme_hist_t lba_mid;
		wme_pkg::wme_hist_t lba_hi;
		logic [7:0] dev_head;
		logic [7:0] dev_ctl;
		logic [7:0] status;
		logic [7:0] error;
		logic [7:0] block_size;
		logic multiple_on;
		logic change_seen;
		logic mcr;
		wme_pkg::wme_state_t state;
		logic [16:0] left;
		logic [16:0] in_block;
		logic [47:0] lba;
		logic [15:0] word;
		logic word_valid;
		logic commit;
		logic intrq;
		logic half;
	} wme_reg_t;
	wme_reg_t r_ff;
	wme_reg_t nxt_r;
	wme_pkg::wme_media_t media;
	logic media_done_s;
	logic [16:0] block_len;
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] pick(input wme_pkg::wme_hist_t h, input logic hob);
		pick = hob ? h.prev : h.cur;
	endfunction : pick
	function automatic wme_pkg::wme_hist_t push(input wme_pkg::wme_hist_t h, input logic [7:0] v);
		push = '{prev: h.cur, cur: v};
	endfunction : push
	function automatic logic [16:0] total(input wme_pkg::wme_hist_t h);
		if ({h.prev, h.cur} == 16'h0000)
			total = wme_pkg::COUNT_ZERO_MEANS;
		else
			total = {1'b0, h.prev, h.cur};
	endfunction : total
	// ****************************************
	// submodules
	// ****************************************
	wme_sync #(.WIDTH(8)) u_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.d({media_in, media_done}),
		.q({media, media_done_s})
	);
	wme_blocker u_blocker
	(
		.sectors_left(r_ff.left),
		.block_size(r_ff.block_size),
		.block_len(block_len)
	);
	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		logic wr_fire;
		logic [7:0] wb;
		logic hob;
		logic [7:0] err;
		wr_fire = 1'b0;
		wb = 8'h00;
		hob = 1'b0;
		err = 8'h00;
		nxt_r = r_ff;
		nxt_r.word_valid = 1'b0;
		nxt_r.commit = 1'b0;
		hob = r_ff.dev_ctl[wme_pkg::CTL_HOB];
		if (media.changed)
			nxt_r.change_seen = 1'b1;
		if (media.change_request)
			nxt_r.mcr = 1'b1;
		// write channels taken in either order
		if (s_axi_awvalid && r_ff.awready)
		begin
			nxt_r.aw_got = 1'b1;
			nxt_r.aw_addr = s_axi_awaddr;
			nxt_r.awready = 1'b0;
		end
		if (s_axi_wvalid && r_ff.wready)
		begin
			nxt_r.w_got = 1'b1;
			nxt_r.w_data = s_axi_wdata;
			nxt_r.w_strb = s_axi_wstrb;
			nxt_r.wready = 1'b0;
		end
		if (r_ff.bvalid && s_axi_bready)
		begin
			nxt_r.bvalid = 1'b0;
			nxt_r.awready = 1'b1;
			nxt_r.wready = 1'b1;
		end
		if (r_ff.aw_got && r_ff.w_got && !r_ff.bvalid)
		begin
			wr_fire = r_ff.w_strb[0];
			wb = r_ff.w_data[7:0];
			nxt_r.aw_got = 1'b0;
			nxt_r.w_got = 1'b0;
			nxt_r.bvalid = 1'b1;
			nxt_r.bresp = (r_ff.aw_addr > wme_pkg::ADDR_PROGRESS) ? wme_pkg::AXI_SLVERR : wme_pkg::AXI_OKAY;
		end
		// taskfile writes blocked while busy, except data and control
		if (wr_fire)
		begin
			case (r_ff.aw_addr)
				wme_pkg::ADDR_DEVICE_CONTROL:
					nxt_r.dev_ctl = wb;
				wme_pkg::ADDR_DATA:
				begin
					if (r_ff.state == wme_pkg::ST_BLOCK && r_ff.in_block != 17'h00000)
					begin
						nxt_r.half = ~r_ff.half;
						nxt_r.word = r_ff.w_data[15:0];
						nxt_r.word_valid = 1'b1;
						if (r_ff.half)
						begin
							// drq stays up across the block, no per-sector handshake
							nxt_r.in_block = r_ff.in_block - 17'h00001;
							nxt_r.left = r_ff.left - 17'h00001;
						end
					end
				end
				default:
				begin
					if (!r_ff.status[wme_pkg::STAT_BSY])
					begin
						case (r_ff.aw_addr)
							wme_pkg::ADDR_TRANSFER_COUNT: nxt_r.count = push(r_ff.count, wb);
							wme_pkg::ADDR_BLOCK_ADDRESS_LOW: nxt_r.lba_lo = push(r_ff.lba_lo, wb);
							wme_pkg::ADDR_BLOCK_ADDRESS_MID: nxt_r.lba_mid = push(r_ff.lba_mid, wb);
							wme_pkg::ADDR_BLOCK_ADDRESS_HIGH: nxt_r.lba_hi = push(r_ff.lba_hi, wb);
							wme_pkg::ADDR_DRIVE_SELECT_HEAD: nxt_r.dev_head = wb;
							wme_pkg::ADDR_MEDIA_EVENT: nxt_r.multiple_on = wb[0];
							wme_pkg::ADDR_COMMAND:
							begin
								nxt_r.intrq = 1'b0;
								nxt_r.error = 8'h00;
								if (wb == wme_pkg::CMD_SET_MULTIPLE)
								begin
									if (r_ff.count.cur != 8'h00)
									begin
										nxt_r.block_size = r_ff.count.cur;
										nxt_r.multiple_on = 1'b1;
									end
									nxt_r.intrq = 1'b1;
								end
								else if (wb == wme_pkg::CMD_GET_MEDIA_STATUS)
								begin
									nxt_r.mcr = 1'b0;
									nxt_r.intrq = 1'b1;
								end
								else if (wb != wme_pkg::CMD_WRITE_MULTIPLE_EXT)
								begin
									nxt_r.error[wme_pkg::ERR_ABRT] = 1'b1;
									nxt_r.status = 8'h41;
									nxt_r.intrq = 1'b1;
								end
								else
								begin
									err[wme_pkg::ERR_ABRT] = ~r_ff.multiple_on;
									err[wme_pkg::ERR_WP] = media.write_protect;
									err[wme_pkg::ERR_MC] = r_ff.change_seen | media.changed;
									err[wme_pkg::ERR_MCR] = r_ff.mcr | media.change_request;
									err[wme_pkg::ERR_NM] = media.no_media;
									// range fault reported as idnf; abort only for disabled mode
									err[wme_pkg::ERR_IDNF] = media.range_error;
									nxt_r.change_seen = 1'b0;
									nxt_r.mcr = 1'b0;
									nxt_r.lba = {r_ff.lba_hi.prev, r_ff.lba_mid.prev, r_ff.lba_lo.prev,
										r_ff.lba_hi.cur, r_ff.lba_mid.cur, r_ff.lba_lo.cur};
									nxt_r.left = total(r_ff.count);
									nxt_r.half = 1'b0;
									if (err != 8'h00)
									begin
										nxt_r.error = err;
										nxt_r.status = 8'h41;
										nxt_r.intrq = 1'b1;
									end
									else
									begin
										nxt_r.status = 8'h80;
										nxt_r.state = wme_pkg::ST_DONE;
									end
								end
							end
							default:
							begin
							end
						endcase
					end
				end
			endcase
		end
		// ****************************************
		// command sequencer
		// ****************************************
		case (r_ff.state)
			wme_pkg::ST_IDLE:
			begin
			end
			wme_pkg::ST_DONE:
			begin
				// open the next block, drq and interrupt pending together
				nxt_r.in_block = block_len;
				nxt_r.status = 8'h48;
				nxt_r.intrq = 1'b1;
				nxt_r.state = wme_pkg::ST_BLOCK;
			end
			wme_pkg::ST_BLOCK:
			begin
				if (r_ff.in_block == 17'h00000)
				begin
					// status goes busy once the whole block is in and stays busy through the media write
					nxt_r.status = 8'h80;
					nxt_r.commit = 1'b1;
					nxt_r.state = wme_pkg::ST_WRITE;
				end
			end
			wme_pkg::ST_WRITE:
			begin
				if (media_done_s)
				begin
					err = 8'h00;
					err[wme_pkg::ERR_IDNF] = media.range_error;
					err[wme_pkg::ERR_WP] = media.write_protect;
					err[wme_pkg::ERR_NM] = media.no_media;
					err[wme_pkg::ERR_ABRT] = media.write_error;
					if (err != 8'h00 || media.fault)
					begin
						// stop at the failing block and report its first lba, no further blocks
						nxt_r.error = err;
						nxt_r.status = {2'b01, media.fault, 4'h0, err != 8'h00};
						nxt_r.lba_lo = '{prev: r_ff.lba[31:24], cur: r_ff.lba[7:0]};
						nxt_r.lba_mid = '{prev: r_ff.lba[39:32], cur: r_ff.lba[15:8]};
						nxt_r.lba_hi = '{prev: r_ff.lba[47:40], cur: r_ff.lba[23:16]};
						nxt_r.intrq = 1'b1;
						nxt_r.state = wme_pkg::ST_IDLE;
					end
					else if (r_ff.left == 17'h00000)
					begin
						nxt_r.status = 8'h40;
						nxt_r.count = '{prev: 8'h00, cur: 8'h00};
						nxt_r.lba_lo = '{prev: 8'h00, cur: 8'h00};
						nxt_r.lba_mid = '{prev: 8'h00, cur: 8'h00};
						nxt_r.lba_hi = '{prev: 8'h00, cur: 8'h00};
						nxt_r.intrq = 1'b1;
						nxt_r.state = wme_pkg::ST_IDLE;
					end
					else
					begin
						// only a full block can be followed by another, so step by the block size
						nxt_r.lba = r_ff.lba + {40'h0000000000, r_ff.block_size};
						nxt_r.state = wme_pkg::ST_DONE;
					end
				end
				else if (r_ff.commit == 1'b0 && r_ff.in_block == 17'h00000)
				begin
					nxt_r.lba = r_ff.lba;
				end
			end
			default:
				nxt_r.state = wme_pkg::ST_IDLE;
		endcase
		// ****************************************
		// read channel
		// ****************************************
		if (r_ff.rvalid && s_axi_rready)
		begin
			nxt_r.rvalid = 1'b0;
			nxt_r.arready = 1'b1;
		end
		if (s_axi_arvalid && r_ff.arready)
		begin
			nxt_r.arready = 1'b0;
			nxt_r.rvalid = 1'b1;
			nxt_r.rresp = wme_pkg::AXI_OKAY;
			nxt_r.rdata = 32'h00000000;
			case (s_axi_araddr)
				wme_pkg::ADDR_ERROR_FLAGS: nxt_r.rdata[7:0] = r_ff.error;
				wme_pkg::ADDR_TRANSFER_COUNT: nxt_r.rdata[7:0] = pick(r_ff.count, hob);
				wme_pkg::ADDR_BLOCK_ADDRESS_LOW: nxt_r.rdata[7:0] = pick(r_ff.lba_lo, hob);
				wme_pkg::ADDR_BLOCK_ADDRESS_MID: nxt_r.rdata[7:0] = pick(r_ff.lba_mid, hob);
				wme_pkg::ADDR_BLOCK_ADDRESS_HIGH: nxt_r.rdata[7:0] = pick(r_ff.lba_hi, hob);
				wme_pkg::ADDR_DRIVE_SELECT_HEAD: nxt_r.rdata[7:0] = r_ff.dev_head;
				wme_pkg::ADDR_COMMAND_STATUS:
				begin
					nxt_r.rdata[7:0] = r_ff.status;
					// a request raised in this very cycle survives the read
					if (nxt_r.intrq == r_ff.intrq)
						nxt_r.intrq = 1'b0;
				end
				wme_pkg::ADDR_DEVICE_CONTROL: nxt_r.rdata[7:0] = r_ff.dev_ctl;
				wme_pkg::ADDR_BLOCK_SIZE: nxt_r.rdata[7:0] = r_ff.block_size;
				wme_pkg::ADDR_MEDIA_EVENT: nxt_r.rdata[7:0] = {5'h00, r_ff.mcr, r_ff.change_seen, r_ff.multiple_on};
				wme_pkg::ADDR_PROGRESS: nxt_r.rdata = {r_ff.state, r_ff.in_block[10:0], r_ff.left};
				wme_pkg::ADDR_COMMAND, wme_pkg::ADDR_DATA: nxt_r.rdata = 32'h00000000;
				default: nxt_r.rresp = wme_pkg::AXI_SLVERR;
			endcase
		end
	end
	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r_ff <= '0;
			r_ff.awready <= 1'b1;
			r_ff.wready <= 1'b1;
			r_ff.arready <= 1'b1;
			r_ff.status <= wme_pkg::RESET_STATUS;
			r_ff.block_size <= wme_pkg::DEFAULT_BLOCK_SIZE;
			r_ff.multiple_on <= 1'b1;
			r_ff.state <= wme_pkg::ST_IDLE;
		end
		else
			r_ff <= nxt_r;
	end
	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = r_ff.awready;
	assign s_axi_wready = r_ff.wready;
	assign s_axi_bvalid = r_ff.bvalid;
	assign s_axi_bresp = r_ff.bresp;
	assign s_axi_arready = r_ff.arready;
	assign s_axi_rvalid = r_ff.rvalid;
	assign s_axi_rdata = r_ff.rdata;
	assign s_axi_rresp = r_ff.rresp;
	assign sector_word = r_ff.word;
	assign sector_word_valid = r_ff.word_valid;
	assign media_lba = r_ff.lba;
	assign media_commit = r_ff.commit;
	assign intrq = r_ff.intrq;
endmodule : wme_top

// File: verif/wme_chk_sva.sv
// checker: handshake and block sequencing properties of wme_top
`timescale 1ns/100ps
module wme_chk
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// media side and interrupt
	input wire logic sector_word_valid,
	input wire logic media_commit,
	input wire logic intrq
);
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_wresp: assert property (p_wresp) else $error("write response late");
	property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rresp: assert property (p_rresp) else $error("read data late");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped before taken");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped before taken");
	property p_commit; media_commit |=> !media_commit; endproperty
	a_commit: assert property (p_commit) else $error("commit longer than one cycle");
	// the interrupt stays low for three cycles after a block commit
	property p_quiet; media_commit |=> !intrq [*3]; endproperty
	a_quiet: assert property (p_quiet) else $error("interrupt during block write");
	property p_noirq; sector_word_valid |=> !$rose(intrq); endproperty
	a_noirq: assert property (p_noirq) else $error("interrupt on an inner sector");
	property p_rst; disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !intrq; endproperty
	a_rst: assert property (p_rst) else $error("outputs active in reset");
	c_commit: cover property (media_commit);
	c_irq: cover property ($rose(intrq));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : wme_chk
bind wme_top wme_chk i_chk (.*);

// File: verif/wme_media_model.sv
// partner: behavioural media mechanics answering block commits
`timescale 1ns/100ps
module wme_media_model
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// from the block
	input wire logic media_commit,
	input wire logic sector_word_valid,
	// condition levels asked for by the bench
	input wire wme_pkg::wme_media_t cond,
	// to the block
	output wme_pkg::wme_media_t media_in,
	output logic media_done,
	// tallies
	output int commits,
	output int words
);
	// ****************************************
	// write timing
	// ****************************************
	int cnt;
	// quick and slow writes alternate; done is held four cycles so the synchroniser sees it
	always @(posedge aclk)
	begin
		media_in <= cond;
		if (!aresetn)
		begin
			cnt <= 0;
			commits <= 0;
			words <= 0;
			media_done <= 1'b0;
		end
		else
		begin
			if (sector_word_valid)
				words <= words + 1;
			if (media_commit)
			begin
				commits <= commits + 1;
				cnt <= commits[0] ? 16 : 6;
			end
			else if (cnt > 0)
				cnt <= cnt - 1;
			media_done <= (cnt > 0 && cnt <= 4);
		end
	end
endmodule : wme_media_model

// File: verif/tb.sv
// testbench: register-level tests of the write multiple ext block
`timescale 1ns/100ps
module tb;
	// ****************************************
	// signals, tasks and tests
	// ****************************************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic sector_word_valid, media_commit, media_done, intrq;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rdat;
	logic [15:0] sector_word;
	logic [47:0] media_lba;
	wme_pkg::wme_media_t media_in;
	wme_pkg::wme_media_t cond = 7'h00;
	int err_total = 0;
	int compares = 0;
	int commits, words, c0, w0, i;
	logic [47:0] lba = 48'h123456789abc;
	logic [6:0] cnd [7] = '{7'h20, 7'h40, 7'h01, 7'h08, 7'h02, 7'h04, 7'h10};
	logic [7:0] eexp [7] = '{8'h20, 8'h40, 8'h10, 8'h02, 8'h04, 8'h00, 8'h08};
	logic [7:0] sexp [7] = '{8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h60, 8'h41};

	always #10 aclk = ~aclk;
	wme_top i_dut (.*);
	wme_media_model i_media (.*);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// ready is raised late on purpose so the slave must hold its answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n == 2) s_axi_bready <= 1'b1;
			if (s_axi_bvalid && s_axi_bready)
			begin
				resp = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		if (n == 50) chk(32'h0, 32'h1);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n == 2) s_axi_rready <= 1'b1;
			if (s_axi_rvalid && s_axi_rready)
			begin
				rdat = s_axi_rdata;
				resp = s_axi_rresp;
				break;
			end
		end
		s_axi_rready <= 1'b0;
		if (n == 50) chk(32'h0, 32'h1);
	endtask : rd

	task automatic wait_irq;
		int n;
		for (n = 0; n < 400 && intrq !== 1'b1; n++)
			@(posedge aclk);
		chk({31'h0, intrq}, 32'h1);
	endtask : wait_irq

	task automatic set_tf(input logic [15:0] c, input logic [47:0] l);
		int r;
		wr(wme_pkg::ADDR_TRANSFER_COUNT, {24'h0, c[15:8]});
		wr(wme_pkg::ADDR_TRANSFER_COUNT, {24'h0, c[7:0]});
		for (r = 0; r < 3; r++)
		begin
			wr(wme_pkg::ADDR_BLOCK_ADDRESS_LOW + 8'(4 * r), {24'h0, l[24 + 8 * r +: 8]});
			wr(wme_pkg::ADDR_BLOCK_ADDRESS_LOW + 8'(4 * r), {24'h0, l[8 * r +: 8]});
		end
		wr(wme_pkg::ADDR_DRIVE_SELECT_HEAD, 32'h40);
	endtask : set_tf

	task automatic chk_lba(input logic [47:0] l);
		int h, r;
		for (h = 0; h < 2; h++)
		begin
			wr(wme_pkg::ADDR_DEVICE_CONTROL, {24'h0, h[0], 7'h0});
			for (r = 0; r < 3; r++)
			begin
				rd(wme_pkg::ADDR_BLOCK_ADDRESS_LOW + 8'(4 * r));
				chk(rdat, {24'h0, l[8 * r + 24 * h +: 8]});
			end
		end
		wr(wme_pkg::ADDR_DEVICE_CONTROL, 32'h0);
	endtask : chk_lba

	task automatic send(input int s);
		int k;
		for (k = 0; k < 2 * s; k++)
			wr(wme_pkg::ADDR_DATA, 32'(k));
	endtask : send

	task automatic status(input logic [7:0] e);
		rd(wme_pkg::ADDR_COMMAND_STATUS);
		chk(rdat, {24'h0, e});
	endtask : status

	task automatic results;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	initial
	begin
		#(20ns * 60000);
		err_total++;
		results();
	end

	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		status(8'h40);
		wr(wme_pkg::ADDR_BLOCK_SIZE, 32'h05);
		rd(wme_pkg::ADDR_BLOCK_SIZE);
		chk(rdat, 32'h10);
		rd(8'h34);
		chk({rdat[29:0], resp}, 32'h2);
		wr(8'h34, 32'h1);
		chk({30'h0, resp}, 32'h2);
		set_tf(16'habcd, lba);
		chk_lba(lba);
		rd(wme_pkg::ADDR_TRANSFER_COUNT);
		chk(rdat, 32'hcd);
		$display("test registers done");
		set_tf(16'h0002, 48'h0);
		wr(wme_pkg::ADDR_COMMAND, {24'h0, wme_pkg::CMD_SET_MULTIPLE});
		wait_irq();
		status(8'h40);
		c0 = commits;
		w0 = words;
		set_tf(16'h0005, 48'h10);
		wr(wme_pkg::ADDR_COMMAND, {24'h0, wme_pkg::CMD_WRITE_MULTIPLE_EXT});
		for (i = 0; i < 3; i++)
		begin
			wait_irq();
			status(8'h48);
			chk(media_lba[31:0], 32'h10 + 32'(2 * i));
			send(i == 2 ? 1 : 2);
			chk({16'h0, sector_word}, i == 2 ? 32'h1 : 32'h3);
		end
		wait_irq();
		status(8'h40);
		chk(32'(commits - c0), 32'h3);
		chk(32'(words - w0), 32'ha);
		rd(wme_pkg::ADDR_BLOCK_ADDRESS_LOW);
		chk(rdat, 32'h0);
		$display("test multi_block done");
		for (i = 0; i < 7; i++)
		begin
			cond <= cnd[i];
			set_tf(16'h0001, lba);
			cond <= cnd[i] & 7'h5f;
			repeat (4) @(posedge aclk);
			wr(wme_pkg::ADDR_COMMAND, {24'h0, wme_pkg::CMD_WRITE_MULTIPLE_EXT});
			wait_irq();
			rd(wme_pkg::ADDR_COMMAND_STATUS);
			if (rdat[3])
			begin
				send(1);
				wait_irq();
				rd(wme_pkg::ADDR_COMMAND_STATUS);
			end
			chk(rdat, {24'h0, sexp[i]});
			rd(wme_pkg::ADDR_ERROR_FLAGS);
			chk(rdat, {24'h0, eexp[i]});
			if (i == 4) chk_lba(lba);
			cond <= 7'h00;
		end
		rd(wme_pkg::ADDR_MEDIA_EVENT);
		chk(rdat, 32'h05);
		wr(wme_pkg::ADDR_COMMAND, {24'h0, wme_pkg::CMD_GET_MEDIA_STATUS});
		wait_irq();
		rd(wme_pkg::ADDR_MEDIA_EVENT);
		chk(rdat, 32'h01);
		$display("test errors done");
		wr(wme_pkg::ADDR_MEDIA_EVENT, 32'h0);
		for (i = 0; i < 2; i++)
		begin
			wr(wme_pkg::ADDR_COMMAND, {24'h0, i == 0 ? wme_pkg::CMD_WRITE_MULTIPLE_EXT : 8'h30});
			wait_irq();
			status(8'h41);
			rd(wme_pkg::ADDR_ERROR_FLAGS);
			chk(rdat, 32'h04);
		end
		wr(wme_pkg::ADDR_MEDIA_EVENT, 32'h1);
		$display("test aborts done");
		set_tf(16'h0000, 48'h0);
		wr(wme_pkg::ADDR_COMMAND, {24'h0, wme_pkg::CMD_WRITE_MULTIPLE_EXT});
		wait_irq();
		rd(wme_pkg::ADDR_PROGRESS);
		chk({15'h0, rdat[16:0]}, 32'h10000);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		status(8'h40);
		$display("test count_zero done");
		results();
	end
endmodule : tb
